// ==== bench/acr_core_exec_sva.sv ====
// Port checker for the execution block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module acr_core_exec_sva (
  input wire logic clock,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic instr_ready,
  input wire logic [7:0] acc,
  input wire logic carry_flag,
  input wire logic half_carry_flag,
  input wire logic zero_flag,
  input wire logic [12:0] pc,
  input wire logic illegal_op
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  logic tk;
  logic [5:0] op;
  logic [2:0] fl;
  assign tk = instr_valid && instr_ready;
  assign op = instr_word[13:8];
  assign fl = {carry_flag, half_carry_flag, zero_flag};
  sequence ret_s;
    tk && instr_word == 14'h0008;
  endsequence
  sequence stall_s;
    !instr_ready ##1 instr_ready;
  endsequence
  ////////////////////////////////////////
  chk_ret_stall: assert property (ret_s |=> stall_s)
    else $error("return stall wrong");
  chk_ret_flags: assert property (ret_s |=> $stable(fl) && $stable(acc))
    else $error("return changed state");
  chk_pc_step: assert property (tk && instr_word != 14'h0008 |=> pc == $past(pc) + 13'h0001)
    else $error("pc step wrong");
  chk_xorl_value: assert property (tk && op == 6'h3a |=> acc == $past(acc ^ instr_word[7:0])
    && zero_flag == (acc == 8'h00) && $stable(fl[2:1]))
    else $error("literal xor wrong");
  chk_subl_value: assert property (tk && op[5:1] == 5'h1e |=> acc == $past(instr_word[7:0] - acc)
    && carry_flag == $past(instr_word[7:0] >= acc)
    && half_carry_flag == $past(instr_word[3:0] >= acc[3:0])
    && zero_flag == (acc == 8'h00))
    else $error("literal subtract wrong");
  chk_bad_load: assert property (tk && op == 6'h31 |=> illegal_op
    && $stable(acc) && $stable(fl))
    else $error("bad literal load not refused");
  chk_noop_quiet: assert property (tk && instr_word == 14'h0000 |=> !illegal_op
    && $stable(acc) && $stable(fl))
    else $error("no-op changed state");
  chk_swap_flags: assert property (tk && op == 6'h0e |=> $stable(fl))
    else $error("swap moved flags");
  chk_rot_flags: assert property (tk && op == 6'h0c |=> $stable(fl[1:0]))
    else $error("rotate moved flags");
  chk_xorf_flags: assert property (tk && op == 6'h06 |=> $stable(fl[2:1]))
    else $error("file xor moved flags");
  chk_load_value: assert property (tk && op == 6'h30 |=> acc == $past(instr_word[7:0])
    && $stable(fl) && !illegal_op)
    else $error("literal load wrong");
endmodule : acr_core_exec_sva

bind acr_core_exec acr_core_exec_sva acr_core_exec_sva_i (.clock, .srst, .instr_valid,
  .instr_word, .instr_ready, .acc, .carry_flag, .half_carry_flag, .zero_flag, .pc, .illegal_op);

// ==== bench/acr_core_exec_tb.sv ====
// Directed bench for the execution block, judged at its ports.
// Assumes the checker binds itself to the block.
`timescale 1ns/1ns
module acr_core_exec_tb;
  logic clock, carry_flag, half_carry_flag, zero_flag, instr_ready, illegal_op;
  logic srst = 1'b1, instr_valid = 1'b0, call_push = 1'b0, seed_write = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [12:0] call_return_addr = 13'h0000;
  logic [12:0] pc;
  logic [6:0] seed_addr = 7'h00, peek_addr = 7'h00;
  logic [7:0] seed_data = 8'h00;
  logic [7:0] peek_data, acc;
  logic [2:0] fl;
  int n_fail = 0;
  int compares = 0;
  assign fl = {carry_flag, half_carry_flag, zero_flag};
  acr_core_exec acr_core_exec_i (.clock, .srst, .instr_valid, .instr_word, .instr_ready,
    .call_push, .call_return_addr, .seed_write, .seed_addr, .seed_data, .peek_addr,
    .peek_data, .acc, .carry_flag, .half_carry_flag, .zero_flag, .pc, .illegal_op);
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ////////////////////////////////////////
  task automatic ck(input logic [12:0] g, input logic [12:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : ck
  // One idle edge first, so valid never drops and rises in one time step;
  // then offered on a falling edge, held until a rising edge sees ready
  task automatic ex(input logic [13:0] w);
    int k;
    @(negedge clock);
    instr_valid = 1'b1;
    instr_word = w;
    for (k = 0; k < 8 && instr_ready !== 1'b1; k++) @(negedge clock);
    if (instr_ready !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] %0t instruction never taken", $time);
    end
    @(negedge clock);
    instr_valid = 1'b0;
  endtask : ex
  task automatic sd(input logic [6:0] a, input logic [7:0] d);
    seed_write = 1'b1;
    seed_addr = a;
    seed_data = d;
    @(negedge clock);
    seed_write = 1'b0;
  endtask : sd
  task automatic pk(input logic [6:0] a, input logic [7:0] e);
    peek_addr = a;
    @(negedge clock);
    ck(peek_data, e);
  endtask : pk
  task automatic t_rot;
    sd(7'h7f, 8'h81);
    ex(14'h0cff);
    pk(7'h7f, 8'h40);
    ck(fl, 3'b100);
    ex(14'h0c7f);
    ck(acc, 8'ha0);
    ck(fl, 3'b000);
    pk(7'h7f, 8'h40);
  endtask : t_rot
  task automatic t_sub;
    ex(14'h3010);
    ex(14'h3c05);
    ck(acc, 8'hf5);
    ck(fl, 3'b010);
    ex(14'h3cf5);
    ck(fl, 3'b111);
    ex(14'h3021);
    sd(7'h10, 8'h20);
    ex(14'h0290);
    ck(fl, 3'b000);
    ck(acc, 8'h21);
    pk(7'h10, 8'hff);
  endtask : t_sub
  task automatic t_swx;
    sd(7'h11, 8'h3c);
    ex(14'h3c21);
    ex(14'h0e11);
    ck(acc, 8'hc3);
    ck(fl, 3'b111);
    ex(14'h0691);
    pk(7'h11, 8'hff);
    ck(fl, 3'b110);
    ex(14'h3ac3);
    ck(acc, 8'h00);
    ck(fl, 3'b111);
  endtask : t_swx
  task automatic t_ret;
    call_push = 1'b1;
    call_return_addr = 13'h0123;
    @(negedge clock);
    call_return_addr = 13'h0456;
    @(negedge clock);
    call_push = 1'b0;
    ex(14'h0008);
    ck(pc, 13'h0456);
    ck(instr_ready, 1'b0);
    ex(14'h0008);
    ck(pc, 13'h0123);
    ck(fl, 3'b111);
    ex(14'h3155);
    ck(illegal_op, 1'b1);
    ck(acc, 8'h00);
    ck(pc, 13'h0124);
    ex(14'h3d07);
    ck(acc, 8'h07);
    ck(fl, 3'b110);
    ex(14'h0000);
    ck(illegal_op, 1'b0);
    ck(pc, 13'h0126);
  endtask : t_ret
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (3) @(negedge clock);
    srst = 1'b0;
    t_rot();
    t_sub();
    t_swx();
    t_ret();
    print_verdict();
  end
  // The run needs under 150 cycles; this allows over ten times that
  initial
  begin
    #20000;
    n_fail++;
    print_verdict();
  end
endmodule : acr_core_exec_tb

// ==== design/acr_core_exec.sv ====
// Execution stage for return, rotate, subtract, swap, XOR and literal load.
// Assumes a fetch unit offering one instruction word at a time with a
// valid/ready handshake, and a call path that pushes return addresses.
`timescale 1ns/1ns

module acr_core_exec #(
  parameter int unsigned file_words = 128
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  input wire logic call_push,
  input wire logic [12:0] call_return_addr,
  input wire logic seed_write,
  input wire logic [6:0] seed_addr,
  input wire logic [7:0] seed_data,
  input wire logic [6:0] peek_addr,
  output logic [7:0] peek_data,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  output logic [12:0] pc,
  output logic illegal_op
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic take;
  logic [5:0] opcode;
  logic dest_file;
  logic [6:0] faddr;
  logic [7:0] literal;
  logic [7:0] fval;
  logic [12:0] stack_top_value;
  logic is_return;
  logic stack_pop;

  assign take = instr_valid && instr_ready;
  assign opcode = instr_word[acr_pkg::op_msb:acr_pkg::op_lsb];
  assign dest_file = instr_word[acr_pkg::dest_bit];
  assign faddr = instr_word[acr_pkg::file_msb:0];
  assign literal = instr_word[acr_pkg::literal_msb:0];
  assign is_return = take && (instr_word == acr_pkg::word_return);
  assign stack_pop = is_return; // RULE_01

  acr_return_stack #(
    .depth(acr_pkg::stack_depth),
    .width(acr_pkg::pc_width)
  ) acr_return_stack_i (
    .clock(clock),
    .srst(srst),
    .push(call_push),
    .push_value(call_return_addr),
    .pop(stack_pop),
    .stack_top_value(stack_top_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: a return holds the handshake off for its second cycle

  acr_pkg::acr_exec_e state;
  acr_pkg::acr_exec_e next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      acr_pkg::acr_exec_run:
      begin
        if (is_return)
        begin
          next_state = acr_pkg::acr_exec_return_tail; // RULE_02
        end
      end
      acr_pkg::acr_exec_return_tail:
      begin
        next_state = acr_pkg::acr_exec_run; // RULE_02
      end
      default:
      begin
        next_state = acr_pkg::acr_exec_run;
      end
    endcase
  end

  assign instr_ready = (state == acr_pkg::acr_exec_run);

  ////////////////////////////////////////////////////////////////////////////
  // Data path

  logic [7:0] file_mem [file_words];
  logic [7:0] result;
  logic write_back;
  logic result_valid;
  logic [7:0] sub_a;
  logic [8:0] sub_sum;
  logic [4:0] sub_low;
  logic next_carry;
  logic next_half_carry;
  logic next_zero;
  logic [7:0] next_acc;
  logic [12:0] next_pc;
  logic next_illegal;
  logic [7:0] next_peek;

  assign fval = file_mem[faddr];

  always_comb
  begin
    result = fval;
    write_back = 1'b0;
    result_valid = 1'b0;
    next_carry = carry_flag;
    next_half_carry = half_carry_flag;
    next_zero = zero_flag;
    next_illegal = 1'b0;
    next_pc = pc;
    // Both subtractions share one adder: a + ~W + 1, carry means no borrow
    // Both literal-minus opcodes must pick the literal, not the file word
    sub_a = (opcode[5:1] == acr_pkg::op_literal_minus_acc[5:1]) ? literal : fval;
    sub_sum = {1'b0, sub_a} + {1'b0, ~acc} + 9'h001;
    sub_low = {1'b0, sub_a[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    if (take && !is_return)
    begin
      next_pc = pc + acr_pkg::pc_step;
      result_valid = 1'b1;
      case (opcode)
        acr_pkg::op_rotate_right_carry:
        begin
          result = {carry_flag, fval[7:1]}; // RULE_03
          next_carry = fval[0]; // RULE_03
          write_back = dest_file; // RULE_04
        end
        acr_pkg::op_file_minus_acc:
        begin
          result = sub_sum[7:0]; // RULE_06
          next_carry = sub_sum[8];
          next_half_carry = sub_low[4];
          next_zero = (sub_sum[7:0] == 8'h00);
          write_back = dest_file; // RULE_04
        end
        acr_pkg::op_nibble_exchange:
        begin
          result = {fval[3:0], fval[7:4]}; // RULE_07
          write_back = dest_file; // RULE_04
        end
        acr_pkg::op_file_xor_acc:
        begin
          result = acc ^ fval; // RULE_08
          next_zero = ((acc ^ fval) == 8'h00);
          write_back = dest_file; // RULE_04
        end
        acr_pkg::op_literal_xor_acc:
        begin
          result = acc ^ literal; // RULE_09
          next_zero = ((acc ^ literal) == 8'h00);
        end
        acr_pkg::op_literal_minus_acc,
        {acr_pkg::op_literal_minus_acc[5:1], 1'b1}:
        begin
          result = sub_sum[7:0]; // RULE_05
          next_carry = sub_sum[8];
          next_half_carry = sub_low[4];
          next_zero = (sub_sum[7:0] == 8'h00);
        end
        acr_pkg::op_load_literal:
        begin
          result = literal; // RULE_10
        end
        default:
        begin
          // Only the all-zero word is a legal no-op; anything else is refused
          result_valid = 1'b0;
          next_illegal = (instr_word != acr_pkg::word_no_op);
        end
      endcase
    end
    else if (is_return)
    begin
      next_pc = stack_top_value; // RULE_01
    end
    next_acc = (result_valid && !write_back) ? result : acc; // RULE_04
    next_peek = file_mem[peek_addr];
  end

  // Core writes win over seeding in the same cycle to the same address
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state <= acr_pkg::acr_exec_run;
      acc <= acr_pkg::acc_reset;
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      pc <= acr_pkg::pc_reset;
      illegal_op <= 1'b0;
      peek_data <= acr_pkg::file_reset;
      for (int i = 0; i < file_words; i++)
      begin
        file_mem[i] <= acr_pkg::file_reset;
      end
    end
    else
    begin
      state <= next_state;
      acc <= next_acc; // RULE_11
      carry_flag <= next_carry;
      half_carry_flag <= next_half_carry;
      zero_flag <= next_zero;
      pc <= next_pc;
      illegal_op <= next_illegal;
      peek_data <= next_peek;
      if (seed_write)
      begin
        file_mem[seed_addr] <= seed_data;
      end
      if (result_valid && write_back)
      begin
        file_mem[faddr] <= result; // RULE_04
      end
    end
  end

endmodule : acr_core_exec

// ==== design/acr_pkg.sv ====
// Constants shared by the accumulator core execution block and its return stack.
// Assumes a 14-bit instruction word and an 8-bit data path on one clock.
// Operation
// [RULE_01] Return pops stack into counter, flags unchanged
// [RULE_02] Return occupies two instruction cycles
// [RULE_03] Rotate right through carry, only carry changes
// [RULE_04] Destination bit: 0 to W, 1 to file
// [RULE_05] Literal minus W into W, sets all flags
// [RULE_06] File minus W to destination, sets all flags
// [RULE_07] Swap nibbles to destination, no flags change
// [RULE_08] File XOR W to destination, only Z
// [RULE_09] Literal XOR W into W, only Z
// [RULE_10] Literal load needs unused operand bits zero
// [RULE_11] Data instructions finish in one cycle
package acr_pkg;

  localparam int unsigned instr_width = 14;
  localparam int unsigned data_width = 8;
  localparam int unsigned file_addr_width = 7;
  localparam int unsigned pc_width = 13;
  localparam int unsigned stack_depth = 8;

  // Field positions inside the instruction word
  localparam int unsigned op_msb = 13;
  localparam int unsigned op_lsb = 8;
  localparam int unsigned dest_bit = 7;
  localparam int unsigned file_msb = 6;
  localparam int unsigned literal_msb = 7;

  // Opcode field values, bits 13:8; return and no-op are whole 14-bit words
  localparam logic [5:0] op_rotate_right_carry = 6'h0c;
  localparam logic [5:0] op_file_minus_acc = 6'h02;
  localparam logic [5:0] op_nibble_exchange = 6'h0e;
  localparam logic [5:0] op_file_xor_acc = 6'h06;
  localparam logic [5:0] op_literal_xor_acc = 6'h3a;
  localparam logic [5:0] op_literal_minus_acc = 6'h3c;
  localparam logic [5:0] op_load_literal = 6'h30;
  localparam logic [13:0] word_return = 14'h0008;
  localparam logic [13:0] word_no_op = 14'h0000;

  // Reset values and program counter step
  localparam logic [7:0] acc_reset = 8'h00;
  localparam logic [7:0] file_reset = 8'h00;
  localparam logic [12:0] pc_reset = 13'h0000;
  localparam logic [12:0] pc_step = 13'h0001;

  typedef enum logic [0:0] {
    acr_exec_run = 1'b0,
    acr_exec_return_tail = 1'b1
  } acr_exec_e;

endpackage : acr_pkg

// ==== design/acr_return_stack.sv ====
// Circular hardware return stack of program counter values.
// Assumes push and pop never arrive in the same cycle; pop wins if they do.
`timescale 1ns/1ns

module acr_return_stack #(
  parameter int unsigned depth = acr_pkg::stack_depth,
  parameter int unsigned width = acr_pkg::pc_width
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic push,
  input wire logic [width-1:0] push_value,
  input wire logic pop,
  output logic [width-1:0] stack_top_value
);

  localparam int unsigned ptr_width = (depth > 1) ? $clog2(depth) : 1;

  logic [width-1:0] slot [depth];
  logic [width-1:0] next_slot [depth];
  logic [ptr_width-1:0] ptr;
  logic [ptr_width-1:0] next_ptr;

  // Wraps silently on overflow and underflow, with no error flag
  always_comb
  begin
    next_ptr = ptr;
    for (int i = 0; i < depth; i++)
    begin
      next_slot[i] = slot[i];
    end
    if (pop)
    begin
      next_ptr = ptr - ptr_width'(1);
    end
    else if (push)
    begin
      next_ptr = ptr + ptr_width'(1);
      next_slot[ptr + ptr_width'(1)] = push_value;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ptr <= '0;
      for (int i = 0; i < depth; i++)
      begin
        slot[i] <= acr_pkg::pc_reset;
      end
    end
    else
    begin
      ptr <= next_ptr;
      slot <= next_slot;
    end
  end

  assign stack_top_value = slot[ptr];

endmodule : acr_return_stack
